//--- core_model.sv
// Purpose: core side issuing I/O, data-space, bit and skip operations
// Assumes: strobes taken at a rising edge, answered one cycle later
// Notes: one operation at a time; address and data shared by all paths
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input wire logic sys_clk,
    input wire logic [7:0] read_data,
    input wire logic read_valid,
    input wire logic skip_taken,
    input wire logic skip_valid,
    output logic [5:0] io_addr,
    output logic io_write,
    output logic io_read,
    output logic [7:0] io_wdata,
    output logic [7:0] ds_addr,
    output logic store_indirect,
    output logic load_indirect,
    output logic [7:0] ds_wdata,
    output logic [4:0] bit_addr,
    output logic [2:0] bit_index,
    output logic bit_set_instruction,
    output logic bit_clear_instruction,
    output logic skip_if_bit_set,
    output logic skip_if_bit_clear
);
    logic [7:0] stb = 8'h00;
    logic [7:0] adr = 8'h00;
    logic [7:0] dat = 8'h00;
    logic [2:0] bix = 3'h0;
    // one strobe vector, one bus fanned out to every path
    assign {skip_if_bit_clear, skip_if_bit_set, bit_clear_instruction} = stb[7:5];
    assign {bit_set_instruction, load_indirect, store_indirect, io_read, io_write} = stb[4:0];
    assign io_addr = adr[5:0];
    assign ds_addr = adr;
    assign bit_addr = adr[4:0];
    assign io_wdata = dat;
    assign ds_wdata = dat;
    assign bit_index = bix;
    // callers choose mapped places and data; breaking either is deliberate
    task automatic op(input logic [7:0] k, input logic [7:0] a, input logic [7:0] d,
        input logic [2:0] b, output logic [7:0] q, output logic s, output logic v);
        @(negedge sys_clk);
        stb = k;
        adr = a;
        dat = d;
        bix = b;
        @(negedge sys_clk);
        stb = 8'h00;
        adr = ~a; // released bus shows a changed value, not the old one
        dat = ~d;
        q = read_data;
        s = skip_taken;
        v = read_valid | skip_valid;
    endtask
endmodule // core_model
`default_nettype wire

//--- io_decoder_asserts.sv
// Purpose: port-level checks of the I/O register bank
// Assumes: one clock, async active-low reset
// Notes: bound to every decoder instance
`timescale 1ns/1ps
`default_nettype none
module io_decoder_asserts (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [5:0] io_addr,
    input wire logic io_write,
    input wire logic io_read,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] ds_addr,
    input wire logic store_indirect,
    input wire logic load_indirect,
    input wire logic [7:0] ds_wdata,
    input wire logic [4:0] bit_addr,
    input wire logic [2:0] bit_index,
    input wire logic bit_set_instruction,
    input wire logic skip_if_bit_set,
    input wire logic skip_if_bit_clear,
    input wire logic [7:0] read_data,
    input wire logic read_valid,
    input wire logic skip_valid,
    input wire logic [7:0] port_b_out,
    input wire logic force_compare_a,
    input wire logic force_compare_b
);
    // single domain, so clock and reset are given once
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    property p_io_rd; io_read && !io_write |=> read_valid; endproperty
    a_io_rd: assert property (p_io_rd) else $error("io read not answered");
    property p_ds_rd; load_indirect && !store_indirect && !io_read && !io_write
        && ds_addr >= 8'h20 && ds_addr <= 8'h5F |=> read_valid; endproperty
    a_ds_rd: assert property (p_ds_rd) else $error("data-space read not answered");
    property p_ds_miss; load_indirect && !io_read && (ds_addr < 8'h20 || ds_addr > 8'h5F)
        |=> !read_valid; endproperty
    a_ds_miss: assert property (p_ds_miss) else $error("read outside window answered");
    // the window offset: 0x38 must return port b output
    property p_ds_map; load_indirect && !store_indirect && !io_read && !io_write
        && ds_addr == 8'h38 |=> read_data == $past(port_b_out); endproperty
    a_ds_map: assert property (p_ds_map) else $error("data-space offset wrong");
    property p_skip; skip_if_bit_set || skip_if_bit_clear |=> skip_valid; endproperty
    a_skip: assert property (p_skip) else $error("skip test not answered");
    property p_rsv; io_read && !io_write && io_addr > 6'h22 |=> read_data == 8'h00; endproperty
    a_rsv: assert property (p_rsv) else $error("unmapped place read nonzero");
    property p_force; io_write && io_addr == 6'h22 && io_wdata[7] |=> force_compare_a; endproperty
    a_force: assert property (p_force) else $error("force pulse missing");
    property p_ds_force; store_indirect && !io_write && !io_read && ds_addr == 8'h42
        && ds_wdata[6] |=> force_compare_b; endproperty
    a_ds_force: assert property (p_ds_force) else $error("store force pulse missing");
    // bit set touches one bit and leaves the rest alone
    property p_bset; bit_set_instruction && bit_addr == 5'h18 && !io_write && !io_read
        && !store_indirect && !load_indirect
        |=> port_b_out == ($past(port_b_out) | (8'h01 << $past(bit_index))); endproperty
    a_bset: assert property (p_bset) else $error("bit set disturbed port b");
endmodule // io_decoder_asserts
bind io_register_space_decoder io_decoder_asserts i_io_decoder_asserts (.sys_clk, .rst_b,
    .io_addr, .io_write, .io_read, .io_wdata, .ds_addr, .store_indirect, .load_indirect,
    .ds_wdata, .bit_addr, .bit_index, .bit_set_instruction, .skip_if_bit_set,
    .skip_if_bit_clear, .read_data, .read_valid, .skip_valid, .port_b_out,
    .force_compare_a, .force_compare_b);
`default_nettype wire

//--- io_register_space_decoder.v
// Purpose: I/O register bank of a small 8-bit controller, seen from the core
// Assumes: core strobes are one-cycle pulses synchronous to sys_clk
// Notes: dedicated I/O, data-space and single-bit paths share one write port
//        bit ops carry 5 address bits
//        unmapped places read zero
//
// Notes on behaviour
// - bit set/clear only reach locations 0x00-0x1F
// - skip tests report one bit, low range
// - flags clear on written one, zero ignored
// - bit set/clear touch only the addressed bit
// - dedicated I/O uses addresses 0x00-0x3F
// - data space maps I/O at plus 0x20
`timescale 1ns/1ps
`default_nettype none

`include "io_space_map.vh"

// one clock, async active-low reset
module io_register_space_decoder (
    input wire sys_clk,
    input wire rst_b,
    input wire [5:0] io_addr,
    input wire io_write,
    input wire io_read,
    input wire [7:0] io_wdata,
    input wire [7:0] ds_addr,
    input wire store_indirect,
    input wire load_indirect,
    input wire [7:0] ds_wdata,
    input wire [4:0] bit_addr,
    input wire [2:0] bit_index,
    input wire bit_set_instruction,
    input wire bit_clear_instruction,
    input wire skip_if_bit_set,
    input wire skip_if_bit_clear,
    input wire [2:0] pin_a_in,
    input wire [7:0] pin_b_in,
    input wire [6:0] pin_d_in,
    input wire [7:0] serial_live,
    input wire comparator_level,
    input wire serial_rx_bit8,
    input wire usi_collision,
    input wire evt_usi_start,
    input wire evt_usi_overflow,
    input wire evt_usi_stop,
    input wire evt_comparator,
    input wire evt_tx_complete,
    input wire evt_watchdog,
    output reg [7:0] read_data,
    output reg read_valid,
    output reg skip_taken,
    output reg skip_valid,
    output wire [2:0] port_a_out,
    output wire [2:0] port_a_dir,
    output wire [7:0] port_b_out,
    output wire [7:0] port_b_dir,
    output wire [6:0] port_d_out,
    output wire [6:0] port_d_dir,
    output reg force_compare_a,
    output reg force_compare_b
);

    // stored bits of each location
    function [7:0] rw_mask;
        input [5:0] a;
        begin
            case (a)
                // serial and comparator bytes
                `OFS_DIGITAL_INPUT_DISABLE: rw_mask = `RW_DIGITAL_INPUT_DISABLE;
                `OFS_BAUD_RATE_HIGH: rw_mask = `RW_BAUD_RATE_HIGH;
                `OFS_SERIAL_FRAME_FORMAT: rw_mask = `RW_SERIAL_FRAME_FORMAT;
                `OFS_COMPARATOR_CONTROL_STATUS: rw_mask = `RW_COMPARATOR;
                `OFS_BAUD_RATE_LOW: rw_mask = `RW_FULL;
                `OFS_SERIAL_CONTROL_B: rw_mask = `RW_SERIAL_CONTROL_B;
                `OFS_SERIAL_STATUS_A: rw_mask = `RW_SERIAL_STATUS_A;
                `OFS_SERIAL_DATA_BUFFER: rw_mask = `RW_FULL;
                `OFS_UNIVERSAL_SERIAL_CONTROL: rw_mask = `RW_FULL;
                `OFS_UNIVERSAL_SERIAL_STATUS: rw_mask = `RW_UNIVERSAL_SERIAL_STATUS;
                `OFS_UNIVERSAL_SERIAL_SHIFT_DATA: rw_mask = `RW_FULL;
                // ports and scratch bytes
                `OFS_PORT_D_DIRECTION: rw_mask = `RW_PORT_D;
                `OFS_PORT_D_OUTPUT: rw_mask = `RW_PORT_D;
                `OFS_SCRATCH_REGISTER_ZERO: rw_mask = `RW_FULL;
                `OFS_SCRATCH_REGISTER_ONE: rw_mask = `RW_FULL;
                `OFS_SCRATCH_REGISTER_TWO: rw_mask = `RW_FULL;
                `OFS_PORT_B_DIRECTION: rw_mask = `RW_FULL;
                `OFS_PORT_B_OUTPUT: rw_mask = `RW_FULL;
                `OFS_PORT_A_DIRECTION: rw_mask = `RW_PORT_A;
                `OFS_PORT_A_OUTPUT: rw_mask = `RW_PORT_A;
                // nonvolatile access
                `OFS_NONVOLATILE_CONTROL: rw_mask = `RW_NONVOLATILE_CONTROL;
                `OFS_NONVOLATILE_DATA: rw_mask = `RW_FULL;
                `OFS_NONVOLATILE_ADDRESS: rw_mask = `RW_NONVOLATILE_ADDRESS;
                // above the bit range
                `OFS_PIN_CHANGE_MASK: rw_mask = `RW_FULL;
                `OFS_WATCHDOG_CONTROL_STATUS: rw_mask = `RW_WATCHDOG;
                default: rw_mask = `RW_NONE; // reserved bits and locations store nothing
            endcase
        end
    endfunction

    // flags that a written one clears
    // flags are not in rw_mask
    function [7:0] w1c_mask;
        input [5:0] a;
        begin
            case (a)
                // one flag, three at 0x0E
                `OFS_COMPARATOR_CONTROL_STATUS: w1c_mask = `W1C_COMPARATOR;
                `OFS_SERIAL_STATUS_A: w1c_mask = `W1C_SERIAL_STATUS_A;
                `OFS_UNIVERSAL_SERIAL_STATUS: w1c_mask = `W1C_UNIVERSAL_SERIAL_STATUS;
                `OFS_WATCHDOG_CONTROL_STATUS: w1c_mask = `W1C_WATCHDOG;
                default: w1c_mask = `RW_NONE;
            endcase
        end
    endfunction

    // one access per cycle; dedicated I/O first, then data space, then bit ops
    reg acc_write;
    reg acc_read;
    reg [5:0] acc_addr;
    reg [7:0] acc_data;
    reg [7:0] acc_lanes;

    // data-space decode
    wire ds_hit;
    wire [7:0] ds_io_addr;
    wire bit_op;

    // data space window 0x20-0x5F folds back onto I/O 0x00-0x3F
    // other addresses are not ours
    assign ds_hit = (ds_addr >= `DS_IO_OFFSET) && (ds_addr <= `DS_IO_LAST);
    assign ds_io_addr = ds_addr - `DS_IO_OFFSET;
    // set wins a set/clear tie
    assign bit_op = bit_set_instruction | bit_clear_instruction;

    // access arbitration and lane selection
    always @* begin
        acc_write = 1'b0;
        acc_read = 1'b0;
        acc_addr = 6'h00;
        acc_data = 8'h00;
        acc_lanes = 8'h00;

        // dedicated I/O wins
        if (io_write || io_read) begin
            acc_write = io_write; // full 6-bit address reaches 0x00-0x3F
            // write wins, no answer
            acc_read = io_read & ~io_write;
            acc_addr = io_addr;
            acc_data = io_wdata;
            acc_lanes = 8'hFF;
        end else if (ds_hit && (store_indirect || load_indirect)) begin
            // data space, window only
            acc_write = store_indirect;
            acc_read = load_indirect & ~store_indirect;
            acc_addr = ds_io_addr[5:0];
            acc_data = ds_wdata;
            acc_lanes = 8'hFF;
        end else if (bit_op) begin
            // 5-bit address keeps bit ops inside 0x00-0x1F
            acc_write = 1'b1;
            acc_addr = {1'b0, bit_addr};
            // one lane only
            acc_data = bit_set_instruction ? 8'hFF : 8'h00;
            acc_lanes = 8'h01 << bit_index; // only the addressed bit is driven
        end
    end

    // hardware event sets, per location
    function [7:0] event_bits;
        input [5:0] a;
        begin
            // levels: held events keep setting
            event_bits = 8'h00;
            case (a)
                `OFS_COMPARATOR_CONTROL_STATUS: begin
                    event_bits[`BIT_COMPARATOR_EVENT] = evt_comparator;
                end
                `OFS_SERIAL_STATUS_A: begin
                    event_bits[`BIT_TX_COMPLETE] = evt_tx_complete;
                end
                // serial-interface flags
                `OFS_UNIVERSAL_SERIAL_STATUS: begin
                    event_bits[`BIT_USI_START] = evt_usi_start;
                    event_bits[`BIT_USI_OVERFLOW] = evt_usi_overflow;
                    event_bits[`BIT_USI_STOP] = evt_usi_stop;
                end
                `OFS_WATCHDOG_CONTROL_STATUS: begin
                    event_bits[`BIT_WATCHDOG_EVENT] = evt_watchdog;
                end
                default: event_bits = 8'h00;
            endcase
        end
    endfunction

    // all stored bits, one byte per location up to the bank top
    wire [`BANK_SLOTS*8-1:0] store_flat;

    // one slot per place
    genvar i;
    generate
        for (i = 0; i < `BANK_SLOTS; i = i + 1) begin : slot
            wire [5:0] my_addr;
            wire hit;
            wire [7:0] keep_mask;
            wire [7:0] flag_mask;
            wire [7:0] wr_bits;
            wire [7:0] clr_bits;
            wire [7:0] set_bits;
            wire [7:0] next_val;
            reg [7:0] val;

            // fixed per slot
            assign my_addr = i[5:0];
            assign hit = acc_write && (acc_addr == my_addr);
            assign keep_mask = rw_mask(my_addr);
            assign flag_mask = w1c_mask(my_addr);

            // reserved bits drop out through the masks
            assign wr_bits = hit ? (acc_lanes & keep_mask) : 8'h00;
            // a written one clears a flag, a zero leaves it
            assign clr_bits = hit ? (acc_lanes & acc_data & flag_mask) : 8'h00;
            assign set_bits = event_bits(my_addr) & flag_mask;
            // write, clear, then events
            assign next_val = (((val & ~wr_bits) | (acc_data & wr_bits)) & ~clr_bits) | set_bits;

            // event set wins over a same-cycle clear
            always @(posedge sys_clk or negedge rst_b) begin
                if (!rst_b) begin
                    // all bits start at zero
                    val <= `IO_RESET_VALUE;
                end else begin
                    val <= next_val;
                end
            end
            assign store_flat[i*8 +: 8] = val;
        end
    endgenerate

    // readback: stored bits plus live peripheral status
    function [7:0] read_of;
        input [5:0] a;
        reg [7:0] stored;
        reg [7:0] live;
        begin
            stored = 8'h00;
            live = 8'h00;

            // stored part, masked
            if (a <= `BANK_TOP_ADDR) begin
                stored = store_flat[{a, 3'b000} +: 8] & (rw_mask(a) | w1c_mask(a));
            end
            // live part
            case (a)
                `OFS_PORT_A_INPUT: live = {5'h00, pin_a_in};
                `OFS_PORT_B_INPUT: live = pin_b_in;
                `OFS_PORT_D_INPUT: live = {1'b0, pin_d_in};
                `OFS_SERIAL_STATUS_A: live = serial_live & `LIVE_SERIAL_STATUS_A;
                `OFS_COMPARATOR_CONTROL_STATUS: begin
                    live[`BIT_COMPARATOR_LEVEL] = comparator_level;
                end
                `OFS_SERIAL_CONTROL_B: begin
                    live[`BIT_SERIAL_RX_BIT8] = serial_rx_bit8;
                end
                `OFS_UNIVERSAL_SERIAL_STATUS: begin
                    live[`BIT_USI_COLLISION] = usi_collision;
                end
                default: live = 8'h00; // reserved and write-only read as zero
            endcase
            read_of = stored | live;
        end
    endfunction

    wire [7:0] test_byte;
    wire test_bit;
    wire skip_req;

    // skip tests read one bit, addressed only inside the low range
    assign test_byte = read_of({1'b0, bit_addr});
    assign test_bit = test_byte[bit_index];
    // clear-skip inverts the bit
    assign skip_req = skip_if_bit_set | skip_if_bit_clear;

    // registered read and skip answers, one cycle after the strobe
    // data answers hold until the next
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            // idle low out of reset
            read_data <= 8'h00;
            read_valid <= 1'b0;
            skip_taken <= 1'b0;
            skip_valid <= 1'b0;
        end else begin
            // one-cycle pulse
            read_valid <= acc_read;
            if (acc_read) begin
                read_data <= read_of(acc_addr);
            end
            // skips run beside reads
            skip_valid <= skip_req;
            if (skip_req) begin
                skip_taken <= skip_if_bit_set ? test_bit : ~test_bit;
            end
        end
    end

    // write-only force strobes; pulse for one cycle, never stored
    // bit ops never reach 0x22
    wire force_hit;
    assign force_hit = acc_write && (acc_addr == `OFS_TIMER16_FORCE_COMPARE);

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            force_compare_a <= 1'b0;
            force_compare_b <= 1'b0;
        end else begin
            // only written ones fire
            force_compare_a <= force_hit & acc_lanes[`BIT_FORCE_COMPARE_A]
                & acc_data[`BIT_FORCE_COMPARE_A];
            force_compare_b <= force_hit & acc_lanes[`BIT_FORCE_COMPARE_B]
                & acc_data[`BIT_FORCE_COMPARE_B];
        end
    end

    // port pads driven straight from stored bytes
    // high bits of a and d unstored
    assign port_a_out = store_flat[{`OFS_PORT_A_OUTPUT, 3'b000} +: 3];
    assign port_a_dir = store_flat[{`OFS_PORT_A_DIRECTION, 3'b000} +: 3];

    assign port_b_out = store_flat[{`OFS_PORT_B_OUTPUT, 3'b000} +: 8];
    assign port_b_dir = store_flat[{`OFS_PORT_B_DIRECTION, 3'b000} +: 8];

    assign port_d_out = store_flat[{`OFS_PORT_D_OUTPUT, 3'b000} +: 7];
    assign port_d_dir = store_flat[{`OFS_PORT_D_DIRECTION, 3'b000} +: 7];

endmodule // io_register_space_decoder

`default_nettype wire

//--- io_space_map.vh
// Purpose: offsets, field masks and reset values of the I/O register bank
// Assumes: 6-bit I/O addresses, 8-bit registers
// Notes: masks mark which bits each register stores, clears or samples
`ifndef IO_SPACE_MAP_VH
`define IO_SPACE_MAP_VH

// address windows
`define IO_TOP_ADDR 6'h3F
`define BIT_SPACE_TOP 6'h1F
`define BANK_TOP_ADDR 6'h22
`define BANK_SLOTS 35
`define DS_IO_OFFSET 8'h20
`define DS_IO_LAST 8'h5F

// register offsets
`define OFS_DIGITAL_INPUT_DISABLE 6'h01
`define OFS_BAUD_RATE_HIGH 6'h02
`define OFS_SERIAL_FRAME_FORMAT 6'h03
`define OFS_COMPARATOR_CONTROL_STATUS 6'h08
`define OFS_BAUD_RATE_LOW 6'h09
`define OFS_SERIAL_CONTROL_B 6'h0A
`define OFS_SERIAL_STATUS_A 6'h0B
`define OFS_SERIAL_DATA_BUFFER 6'h0C
`define OFS_UNIVERSAL_SERIAL_CONTROL 6'h0D
`define OFS_UNIVERSAL_SERIAL_STATUS 6'h0E
`define OFS_UNIVERSAL_SERIAL_SHIFT_DATA 6'h0F
`define OFS_PORT_D_INPUT 6'h10
`define OFS_PORT_D_DIRECTION 6'h11
`define OFS_PORT_D_OUTPUT 6'h12
`define OFS_SCRATCH_REGISTER_ZERO 6'h13
`define OFS_SCRATCH_REGISTER_ONE 6'h14
`define OFS_SCRATCH_REGISTER_TWO 6'h15
`define OFS_PORT_B_INPUT 6'h16
`define OFS_PORT_B_DIRECTION 6'h17
`define OFS_PORT_B_OUTPUT 6'h18
`define OFS_PORT_A_INPUT 6'h19
`define OFS_PORT_A_DIRECTION 6'h1A
`define OFS_PORT_A_OUTPUT 6'h1B
`define OFS_NONVOLATILE_CONTROL 6'h1C
`define OFS_NONVOLATILE_DATA 6'h1D
`define OFS_NONVOLATILE_ADDRESS 6'h1E
`define OFS_PIN_CHANGE_MASK 6'h20
`define OFS_WATCHDOG_CONTROL_STATUS 6'h21
`define OFS_TIMER16_FORCE_COMPARE 6'h22

// stored (read/write) bit masks
`define RW_FULL 8'hFF
`define RW_NONE 8'h00
`define RW_DIGITAL_INPUT_DISABLE 8'h03
`define RW_BAUD_RATE_HIGH 8'h0F
`define RW_SERIAL_FRAME_FORMAT 8'h7F
`define RW_COMPARATOR 8'hCF
`define RW_SERIAL_CONTROL_B 8'hFD
`define RW_SERIAL_STATUS_A 8'h03
`define RW_UNIVERSAL_SERIAL_STATUS 8'h0F
`define RW_PORT_D 8'h7F
`define RW_PORT_A 8'h07
`define RW_NONVOLATILE_CONTROL 8'h3F
`define RW_NONVOLATILE_ADDRESS 8'h7F
`define RW_WATCHDOG 8'h7F

// write-one-to-clear flag masks
`define W1C_COMPARATOR 8'h10
`define W1C_SERIAL_STATUS_A 8'h40
`define W1C_UNIVERSAL_SERIAL_STATUS 8'hE0
`define W1C_WATCHDOG 8'h80

// live status bits sampled from the peripherals, then event flag and force strobe bit positions
`define LIVE_SERIAL_STATUS_A 8'hBC
`define BIT_COMPARATOR_LEVEL 5
`define BIT_SERIAL_RX_BIT8 1
`define BIT_USI_COLLISION 4
`define BIT_USI_START 7
`define BIT_USI_OVERFLOW 6
`define BIT_USI_STOP 5
`define BIT_COMPARATOR_EVENT 4
`define BIT_TX_COMPLETE 6
`define BIT_WATCHDOG_EVENT 7
`define BIT_FORCE_COMPARE_A 7
`define BIT_FORCE_COMPARE_B 6

// reset values
`define IO_RESET_VALUE 8'h00

`endif

//--- tb_io_register_space_decoder.sv
// Purpose: self-checking bench for the I/O register bank
// Assumes: core model issues one operation at a time
// Notes: peripheral inputs are driven here at the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb_io_register_space_decoder;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [5:0] io_addr, evt;
    logic [7:0] io_wdata, ds_addr, ds_wdata, read_data, pin_b_in, serial_live, port_b_out;
    logic [7:0] port_b_dir, q;
    logic [4:0] bit_addr;
    logic [2:0] bit_index, pin_a_in, port_a_out, port_a_dir, lvl;
    logic [6:0] pin_d_in, port_d_out, port_d_dir;
    logic io_write, io_read, store_indirect, load_indirect, bit_set_instruction, s, v;
    logic bit_clear_instruction, skip_if_bit_set, skip_if_bit_clear, read_valid, skip_taken;
    logic skip_valid, comparator_level, serial_rx_bit8, usi_collision, evt_usi_start;
    logic evt_usi_overflow, evt_usi_stop, evt_comparator, evt_tx_complete, evt_watchdog;
    logic force_compare_a, force_compare_b;
    int errors = 0;
    int check_count = 0;
    localparam logic [7:0] k_iow = 8'h01, k_ior = 8'h02, k_st = 8'h04, k_ld = 8'h08;
    localparam logic [7:0] k_set = 8'h10, k_clr = 8'h20, k_sks = 8'h40, k_skc = 8'h80;
    logic [7:0] ofs [8] = '{8'h02, 8'h03, 8'h09, 8'h14, 8'h17, 8'h1A, 8'h1E, 8'h20};
    logic [7:0] msk [8] = '{8'h0F, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'h07, 8'h7F, 8'hFF};

    io_register_space_decoder i_io_register_space_decoder (.sys_clk, .rst_b, .io_addr,
        .io_write, .io_read, .io_wdata, .ds_addr, .store_indirect, .load_indirect, .ds_wdata,
        .bit_addr, .bit_index, .bit_set_instruction, .bit_clear_instruction, .skip_if_bit_set,
        .skip_if_bit_clear, .pin_a_in, .pin_b_in, .pin_d_in, .serial_live, .comparator_level,
        .serial_rx_bit8, .usi_collision, .evt_usi_start, .evt_usi_overflow, .evt_usi_stop,
        .evt_comparator, .evt_tx_complete, .evt_watchdog, .read_data, .read_valid,
        .skip_taken, .skip_valid, .port_a_out, .port_a_dir, .port_b_out, .port_b_dir,
        .port_d_out, .port_d_dir, .force_compare_a, .force_compare_b);
    core_model i_core_model (.sys_clk, .read_data, .read_valid, .skip_taken, .skip_valid,
        .io_addr, .io_write, .io_read, .io_wdata, .ds_addr, .store_indirect, .load_indirect,
        .ds_wdata, .bit_addr, .bit_index, .bit_set_instruction, .bit_clear_instruction,
        .skip_if_bit_set, .skip_if_bit_clear);

    // 20 MHz clock and grouped peripheral drives
    always #25 sys_clk = ~sys_clk;
    assign {evt_usi_start, evt_usi_overflow, evt_usi_stop} = evt[5:3];
    assign {evt_comparator, evt_tx_complete, evt_watchdog} = evt[2:0];
    assign {comparator_level, serial_rx_bit8, usi_collision} = lvl;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    // one access, answer flag always judged, data only when an answer is due
    task automatic xchk(input logic [7:0] k, input logic [7:0] a, input logic [7:0] e,
        input logic ev);
        i_core_model.op(k, a, 8'h00, 3'h0, q, s, v);
        check({7'h0, v}, {7'h0, ev});
        if (ev) check(q, e);
    endtask
    task automatic wr(input logic [7:0] k, input logic [7:0] a, input logic [7:0] d);
        i_core_model.op(k, a, d, 3'h0, q, s, v);
    endtask
    task automatic bop(input logic [7:0] k, input logic [7:0] a, input logic [2:0] b);
        i_core_model.op(k, a, 8'h00, b, q, s, v);
    endtask
    // reset values, stored masks, both address paths and the window edges
    task automatic t_regs;
        for (int i = 0; i < 8; i++) begin
            xchk(k_ior, ofs[i], 8'h00, 1'b1);
            wr(k_iow, ofs[i], 8'hFF); // reserved bits written on purpose
            xchk(k_ior, ofs[i], msk[i], 1'b1);
            wr(k_st, ofs[i] + 8'h20, 8'h00);
            xchk(k_ld, ofs[i] + 8'h20, 8'h00, 1'b1);
        end
        xchk(k_ior, 8'h30, 8'h00, 1'b1);
        xchk(k_ior, 8'h05, 8'h00, 1'b1);
        xchk(k_ld, 8'h5F, 8'h00, 1'b1);
        xchk(k_ld, 8'h60, 8'h00, 1'b0);
        xchk(k_ld, 8'h1F, 8'h00, 1'b0);
    endtask
    // sticky flags, live bits and their clearing by written ones
    task automatic t_events;
        @(negedge sys_clk);
        pin_a_in = 3'h5;
        pin_d_in = 7'h2A;
        serial_live = 8'hFF;
        lvl = 3'h7;
        evt = 6'h3F;
        @(negedge sys_clk);
        evt = 6'h00;
        xchk(k_ior, 8'h08, 8'h30, 1'b1);
        xchk(k_ior, 8'h0B, 8'hFC, 1'b1);
        xchk(k_ior, 8'h0A, 8'h02, 1'b1);
        xchk(k_ior, 8'h0E, 8'hF0, 1'b1);
        xchk(k_ior, 8'h21, 8'h80, 1'b1);
        xchk(k_ior, 8'h19, 8'h05, 1'b1);
        xchk(k_ior, 8'h10, 8'h2A, 1'b1);
        wr(k_iow, 8'h0B, 8'h40);
        xchk(k_ior, 8'h0B, 8'hBC, 1'b1);
        wr(k_iow, 8'h08, 8'h00);
        xchk(k_ior, 8'h08, 8'h30, 1'b1);
        wr(k_st, 8'h28, 8'h10);
        xchk(k_ior, 8'h08, 8'h20, 1'b1);
    endtask
    // single-bit set and clear beside flags, then skip tests on port b pins
    task automatic t_bits;
        bop(k_set, 8'h0E, 3'h6);
        xchk(k_ior, 8'h0E, 8'hB0, 1'b1);
        bop(k_clr, 8'h0E, 3'h7);
        xchk(k_ior, 8'h0E, 8'hB0, 1'b1);
        bop(k_set, 8'h0E, 3'h0);
        xchk(k_ior, 8'h0E, 8'hB1, 1'b1);
        wr(k_iow, 8'h18, 8'h0F);
        bop(k_set, 8'h18, 3'h7);
        check(port_b_out, 8'h8F);
        bop(k_clr, 8'h18, 3'h0);
        check(port_b_out, 8'h8E);
        xchk(k_ld, 8'h38, 8'h8E, 1'b1);
        wr(k_iow, 8'h17, 8'hA5);
        check(port_b_dir, 8'hA5);
        wr(k_iow, 8'h1B, 8'hFF);
        check({5'h00, port_a_out}, 8'h07);
        bop(k_set, 8'h1A, 3'h2);
        check({5'h00, port_a_dir}, 8'h04);
        wr(k_st, 8'h31, 8'hFF);
        check({1'h0, port_d_dir}, 8'h7F);
        wr(k_st, 8'h32, 8'h55);
        check({1'h0, port_d_out}, 8'h55);
        for (int i = 0; i < 4; i++) begin
            bop(i[0] ? k_skc : k_sks, 8'h16, {2'b00, i[1]});
            check({7'h0, s}, {7'h0, i[0] ^ pin_b_in[i[1]]});
            check({7'h0, v}, 8'h01);
        end
    endtask
    // force strobes from both paths, and the register reads back zero
    task automatic t_force;
        wr(k_iow, 8'h22, 8'hC0);
        check({6'h0, force_compare_a, force_compare_b}, 8'h03);
        wr(k_st, 8'h42, 8'h40);
        check({6'h0, force_compare_a, force_compare_b}, 8'h01);
        xchk(k_ior, 8'h22, 8'h00, 1'b1);
    endtask
    task automatic complete_run;
        if (errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // main sequence: inputs at zero except pin_b_in at 0x5A, reset for 16 cycles, then scenarios
    initial begin
        pin_a_in = 3'h0;
        pin_b_in = 8'h5A;
        pin_d_in = 7'h00;
        serial_live = 8'h00;
        lvl = 3'h0;
        evt = 6'h00;
        repeat (16) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_b = 1'b1;
        t_regs;
        t_events;
        t_bits;
        t_force;
        complete_run;
    end
    // runs take about 180 cycles, so this span means a hang
    initial begin
        repeat (3000) @(posedge sys_clk);
        errors++;
        complete_run;
    end
endmodule // tb_io_register_space_decoder
`default_nettype wire
